// ===== common/amis_cfg.svh
// Purpose: Constants for the audio mute input select block
// Assumes: Plain register port with byte addresses as printed
// Notes: Offsets are byte addresses
`ifndef AMIS_CFG_SVH
`define AMIS_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define AMIS_ADDR_W 32
`define AMIS_DATA_W 32
`define AMIS_PORT1_CFG_ADDR 32'h4000001c
`define AMIS_PORT2_CFG_ADDR 32'h40000020
`define AMIS_SEL_LSB 0
`define AMIS_SEL_MSB 2
`define AMIS_SEL_RESET 3'h0

// ****************************************
// Select codes
// ****************************************
`define AMIS_SEL_ZERO 3'h0
`define AMIS_SEL_SER7 3'h1
`define AMIS_SEL_SER8 3'h2
`define AMIS_SEL_SER9 3'h3
`define AMIS_SEL_HRCLK 3'h4
`define AMIS_SEL_SP0_MOSI 3'h5
`define AMIS_SEL_SP0_CS 3'h6
`define AMIS_SEL_SP0_ENA 3'h7
`endif

// ===== common/amis_pkg.sv
// Purpose: Types for the audio mute input select block
// Assumes: Constants come from amis_cfg.svh
// Notes: None
`include "amis_cfg.svh"
package amis_pkg;
  typedef logic [2:0] amis_sel_t;

  // Candidate sources shared by both ports
  typedef struct packed {
    logic first_serial_periph_enable;
    logic first_serial_periph_chip_select;
    logic first_serial_periph_mosi;
    logic third_port_high_rate_rx_clock;
    logic ser_pin9;
    logic ser_pin8;
    logic ser_pin7;
  } amis_src_t;

  typedef struct packed {
    logic [`AMIS_ADDR_W-1:0] addr;
    logic [`AMIS_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } amis_bus_t;
endpackage : amis_pkg

// ===== src/amis_mux.sv
// Purpose: One mute source multiplexer
// Assumes: Sources synchronous to clock_in
// Notes: Purely combinational
`timescale 1ns/1ns
`include "amis_cfg.svh"
module amis_mux (
  input wire amis_pkg::amis_sel_t sel_in,
  input wire amis_pkg::amis_src_t src_in,
  output logic mute_out
);
  // ****************************************
  // Selection
  // ****************************************
  wire [7:0] cand;
  assign cand = {src_in.first_serial_periph_enable,
                 src_in.first_serial_periph_chip_select,
                 src_in.first_serial_periph_mosi,
                 src_in.third_port_high_rate_rx_clock,
                 src_in.ser_pin9, src_in.ser_pin8, src_in.ser_pin7,
                 1'b0};
  assign mute_out = cand[sel_in];
endmodule : amis_mux

// ===== src/amis_top.sv
// Purpose: Mute input source select for second and third audio ports
// Assumes: Register port, read data one cycle after read strobe
// Notes: Upper bits read as zero
// Operation
// - Second port field selects its mute source
// - Third port field selects independently, same codes
// - Code zero drives constant low
// - Codes map to shared serializer, clock, serial pins
`timescale 1ns/1ns
`include "amis_cfg.svh"
module amis_top (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [`AMIS_ADDR_W-1:0] addr_in,
  input wire logic [`AMIS_DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`AMIS_DATA_W-1:0] rdata_out,
  input wire amis_pkg::amis_src_t src_in,
  output logic second_port_mute_out,
  output logic third_port_mute_out
);
  // ****************************************
  // Decode
  // ****************************************
  amis_pkg::amis_sel_t second_port_mute_source_sel_reg;
  amis_pkg::amis_sel_t third_port_mute_source_sel_reg;
  amis_pkg::amis_sel_t second_next;
  amis_pkg::amis_sel_t third_next;
  logic [`AMIS_DATA_W-1:0] rdata_reg;
  logic [`AMIS_DATA_W-1:0] rdata_next;
  amis_pkg::amis_bus_t bus_req;
  wire hit1;
  wire hit2;
  wire [1:0][2:0] sel_vec;
  wire [1:0] mute_vec;

  // Address compare shared by both configuration words
  function automatic logic cfg_hit(
    input logic [`AMIS_ADDR_W-1:0] addr,
    input logic [`AMIS_ADDR_W-1:0] target
  );
    return addr == target;
  endfunction : cfg_hit

  // Table form of the code map, kept apart from the mux wiring so checks stay independent
  function automatic logic ref_pick(
    input amis_pkg::amis_sel_t sel,
    input amis_pkg::amis_src_t src
  );
    logic pick;
    pick = 1'b0;
    case (sel)
      `AMIS_SEL_ZERO: pick = 1'b0;
      `AMIS_SEL_SER7: pick = src.ser_pin7;
      `AMIS_SEL_SER8: pick = src.ser_pin8;
      `AMIS_SEL_SER9: pick = src.ser_pin9;
      `AMIS_SEL_HRCLK: pick = src.third_port_high_rate_rx_clock;
      `AMIS_SEL_SP0_MOSI: pick = src.first_serial_periph_mosi;
      `AMIS_SEL_SP0_CS: pick = src.first_serial_periph_chip_select;
      `AMIS_SEL_SP0_ENA: pick = src.first_serial_periph_enable;
      default: pick = 1'b0;
    endcase
    return pick;
  endfunction : ref_pick

  assign bus_req = {addr_in, wdata_in, wr_in, rd_in};
  assign hit1 = cfg_hit(bus_req.addr, `AMIS_PORT1_CFG_ADDR);
  assign hit2 = cfg_hit(bus_req.addr, `AMIS_PORT2_CFG_ADDR);
  // Upper bits are ignored on write; software is expected to write zeros
  assign second_next = (wr_in && hit1) ?
    wdata_in[`AMIS_SEL_MSB:`AMIS_SEL_LSB] : second_port_mute_source_sel_reg;
  assign third_next = (wr_in && hit2) ?
    wdata_in[`AMIS_SEL_MSB:`AMIS_SEL_LSB] : third_port_mute_source_sel_reg;
  // Reserved bits read zero, a safe choice of the indeterminate value
  assign rdata_next = !rd_in ? '0 :
    hit1 ? {29'h0000000, second_port_mute_source_sel_reg} :
    hit2 ? {29'h0000000, third_port_mute_source_sel_reg} : '0;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      second_port_mute_source_sel_reg <= `AMIS_SEL_RESET;
      third_port_mute_source_sel_reg <= `AMIS_SEL_RESET;
      rdata_reg <= '0;
    end else begin
      second_port_mute_source_sel_reg <= second_next;
      third_port_mute_source_sel_reg <= third_next;
      rdata_reg <= rdata_next;
    end
  end
  assign rdata_out = rdata_reg;

  // ****************************************
  // Multiplexers
  // ****************************************
  assign sel_vec[0] = second_port_mute_source_sel_reg;
  assign sel_vec[1] = third_port_mute_source_sel_reg;
  // Same mux for each port; slot 0 is the second audio port
  for (genvar g = 0; g < 2; g++) begin : g_port
    amis_mux u_mux (
      .sel_in(sel_vec[g]),
      .src_in(src_in),
      .mute_out(mute_vec[g])
    );
  end
  assign second_port_mute_out = mute_vec[0];
  assign third_port_mute_out = mute_vec[1];

  // ****************************************
  // Assertions
  // ****************************************
  // ****************************************
  // Register writes
  // ****************************************
  second_write_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    wr_in && hit1
    |=> second_port_mute_source_sel_reg == $past(wdata_in[2:0]))
    else $error("second select not written");

  third_write_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    wr_in && hit2
    |=> third_port_mute_source_sel_reg == $past(wdata_in[2:0]))
    else $error("third select not written");

  second_keep_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    !(wr_in && hit1)
    |=> $stable(second_port_mute_source_sel_reg))
    else $error("second select changed");

  third_keep_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    !(wr_in && hit2)
    |=> $stable(third_port_mute_source_sel_reg))
    else $error("third select changed");

  unmapped_keep_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    wr_in && !hit1 && !hit2
    |=> $stable(second_port_mute_source_sel_reg) && $stable(third_port_mute_source_sel_reg))
    else $error("unmapped write changed a select");

  // ****************************************
  // Reset
  // ****************************************
  reset_sel_a: assert property (
    @(posedge clock_in)
    !resetn_in
    |=> second_port_mute_source_sel_reg == `AMIS_SEL_RESET
      && third_port_mute_source_sel_reg == `AMIS_SEL_RESET)
    else $error("select not cleared by reset");

  reset_mute_a: assert property (
    @(posedge clock_in)
    !resetn_in
    |=> !second_port_mute_out && !third_port_mute_out)
    else $error("mute not low after reset");

  // ****************************************
  // Read path
  // ****************************************
  read_second_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    rd_in && hit1
    |=> rdata_out == {29'h0, $past(second_port_mute_source_sel_reg)})
    else $error("second read wrong");

  read_third_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    rd_in && hit2
    |=> rdata_out == {29'h0, $past(third_port_mute_source_sel_reg)})
    else $error("third read wrong");

  read_reserved_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    rd_in && (hit1 || hit2)
    |=> rdata_out[31:3] == 29'h0)
    else $error("reserved bits not zero");

  read_unmapped_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    rd_in && !hit1 && !hit2
    |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");

  // ****************************************
  // Second port code map
  // ****************************************
  zero_low_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    second_port_mute_source_sel_reg == `AMIS_SEL_ZERO
    |-> !second_port_mute_out)
    else $error("zero code not low");

  ser7_map_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    second_port_mute_source_sel_reg == `AMIS_SEL_SER7
    |-> second_port_mute_out == src_in.ser_pin7)
    else $error("code one wrong");

  second_ser8_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    second_port_mute_source_sel_reg == `AMIS_SEL_SER8
    |-> second_port_mute_out == src_in.ser_pin8)
    else $error("second code two wrong");

  second_ser9_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    second_port_mute_source_sel_reg == `AMIS_SEL_SER9
    |-> second_port_mute_out == src_in.ser_pin9)
    else $error("second code three wrong");

  second_hrclk_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    second_port_mute_source_sel_reg == `AMIS_SEL_HRCLK
    |-> second_port_mute_out == src_in.third_port_high_rate_rx_clock)
    else $error("second code four wrong");

  second_mosi_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    second_port_mute_source_sel_reg == `AMIS_SEL_SP0_MOSI
    |-> second_port_mute_out == src_in.first_serial_periph_mosi)
    else $error("second code five wrong");

  second_cs_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    second_port_mute_source_sel_reg == `AMIS_SEL_SP0_CS
    |-> second_port_mute_out == src_in.first_serial_periph_chip_select)
    else $error("second code six wrong");

  ena_map_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    second_port_mute_source_sel_reg == `AMIS_SEL_SP0_ENA
    |-> second_port_mute_out == src_in.first_serial_periph_enable)
    else $error("code seven wrong");

  second_ref_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    $changed(src_in) || $changed(second_port_mute_source_sel_reg)
    |-> second_port_mute_out == ref_pick(second_port_mute_source_sel_reg, src_in))
    else $error("second mute differs from table");

  // ****************************************
  // Third port code map
  // ****************************************
  third_zero_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    third_port_mute_source_sel_reg == `AMIS_SEL_ZERO
    |-> !third_port_mute_out)
    else $error("third zero code not low");

  third_ser7_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    third_port_mute_source_sel_reg == `AMIS_SEL_SER7
    |-> third_port_mute_out == src_in.ser_pin7)
    else $error("third code one wrong");

  third_ser8_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    third_port_mute_source_sel_reg == `AMIS_SEL_SER8
    |-> third_port_mute_out == src_in.ser_pin8)
    else $error("third code two wrong");

  third_ser9_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    third_port_mute_source_sel_reg == `AMIS_SEL_SER9
    |-> third_port_mute_out == src_in.ser_pin9)
    else $error("third code three wrong");

  hrclk_map_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    third_port_mute_source_sel_reg == `AMIS_SEL_HRCLK
    |-> third_port_mute_out == src_in.third_port_high_rate_rx_clock)
    else $error("clock code wrong");

  third_mosi_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    third_port_mute_source_sel_reg == `AMIS_SEL_SP0_MOSI
    |-> third_port_mute_out == src_in.first_serial_periph_mosi)
    else $error("third code five wrong");

  third_cs_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    third_port_mute_source_sel_reg == `AMIS_SEL_SP0_CS
    |-> third_port_mute_out == src_in.first_serial_periph_chip_select)
    else $error("third code six wrong");

  third_ena_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    third_port_mute_source_sel_reg == `AMIS_SEL_SP0_ENA
    |-> third_port_mute_out == src_in.first_serial_periph_enable)
    else $error("third code seven wrong");

  third_ref_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    $changed(src_in) || $changed(third_port_mute_source_sel_reg)
    |-> third_port_mute_out == ref_pick(third_port_mute_source_sel_reg, src_in))
    else $error("third mute differs from table");

  // ****************************************
  // Forwarding
  // ****************************************
  direct_fwd_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    wr_in && hit1 && wdata_in[2:0] == `AMIS_SEL_SER8
    |=> second_port_mute_out == src_in.ser_pin8)
    else $error("select not immediate");

  third_fwd_a: assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    wr_in && hit2 && wdata_in[2:0] == `AMIS_SEL_SP0_CS
    |=> third_port_mute_out == src_in.first_serial_periph_chip_select)
    else $error("third select not immediate");

endmodule : amis_top

// ===== testbench/amis_tb.sv
// Purpose: Self-checking bench for mute source select
// Assumes: Read data one cycle after read strobe
// Notes: Reserved bits expected to read zero
`timescale 1ns/1ns
`include "amis_cfg.svh"
module testbench;
  logic clock_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0, rd_q = 0;
  logic [31:0] addr_in = '0, wdata_in = '0, rdata_out;
  amis_pkg::amis_src_t src_in = '0;
  logic second_port_mute_out, third_port_mute_out;
  logic [31:0] exp_q[$];
  logic [2:0] s2, s3;
  int err_total = 0, comparisons = 0;
  amis_top DUT (.clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .src_in(src_in), .second_port_mute_out(second_port_mute_out),
    .third_port_mute_out(third_port_mute_out));
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp(string name, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, e, s);
    end
  endtask : cmp
  // Expected mute level per code, from the code constants
  function automatic logic mux_of(logic [2:0] s, amis_pkg::amis_src_t v);
    case (s)
      `AMIS_SEL_SER7: return v.ser_pin7;
      `AMIS_SEL_SER8: return v.ser_pin8;
      `AMIS_SEL_SER9: return v.ser_pin9;
      `AMIS_SEL_HRCLK: return v.third_port_high_rate_rx_clock;
      `AMIS_SEL_SP0_MOSI: return v.first_serial_periph_mosi;
      `AMIS_SEL_SP0_CS: return v.first_serial_periph_chip_select;
      `AMIS_SEL_SP0_ENA: return v.first_serial_periph_enable;
      default: return 1'b0;
    endcase
  endfunction : mux_of
  // One bus cycle; idle call ends a burst so no strobe is set twice in a step
  task automatic bus(logic w, logic r, logic [31:0] a, logic [31:0] d, logic [31:0] e);
    wr_in <= w;
    rd_in <= r;
    addr_in <= a;
    wdata_in <= d;
    if (r) exp_q.push_back(e);
    @(posedge clock_in);
  endtask : bus
  task automatic chk_mute();
    #10;
    cmp("second_mute", {31'h0, mux_of(s2, src_in)}, {31'h0, second_port_mute_out});
    cmp("third_mute", {31'h0, mux_of(s3, src_in)}, {31'h0, third_port_mute_out});
  endtask : chk_mute
  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Watcher: read data is valid only in the cycle after the strobe
  always @(posedge clock_in) begin
    rd_q <= rd_in;
    if (rd_q && exp_q.size() > 0) cmp("rdata", exp_q.pop_front(), rdata_out);
  end
  initial begin
    void'($urandom(46));
    s2 = 3'h0;
    s3 = 3'h0;
    repeat (8) @(posedge clock_in);
    resetn_in <= 1'b1;
    src_in <= amis_pkg::amis_src_t'($urandom);
    bus(0, 1, `AMIS_PORT1_CFG_ADDR, 32'h0, {29'h0, `AMIS_SEL_RESET});
    bus(0, 1, `AMIS_PORT2_CFG_ADDR, 32'h0, {29'h0, `AMIS_SEL_RESET});
    bus(0, 0, 32'h0, 32'h0, 32'h0);
    chk_mute();
    for (int i = 0; i < 64; i++) begin
      @(posedge clock_in);
      s2 = i[2:0];
      s3 = i[5:3];
      bus(1, 0, `AMIS_PORT1_CFG_ADDR, {29'h0, s2}, 0);
      bus(1, 0, `AMIS_PORT2_CFG_ADDR, {29'h0, s3}, 0);
      bus(1, 0, 32'h40000018, {29'h0, ~s2}, 32'h0);
      bus(0, 1, `AMIS_PORT1_CFG_ADDR, 0, {29'h0, s2});
      bus(0, 1, `AMIS_PORT2_CFG_ADDR, 0, {29'h0, s3});
      bus(0, 1, 32'h40000018, 0, 32'h0);
      bus(0, 0, 0, 0, 0);
      chk_mute();
      repeat (2) begin
        @(posedge clock_in);
        src_in <= amis_pkg::amis_src_t'($urandom);
        chk_mute();
      end
    end
    // Mid-run reset with both selects nonzero
    @(posedge clock_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    resetn_in <= 1'b1;
    s2 = `AMIS_SEL_RESET;
    s3 = `AMIS_SEL_RESET;
    bus(0, 1, `AMIS_PORT1_CFG_ADDR, 32'h0, {29'h0, `AMIS_SEL_RESET});
    bus(0, 1, `AMIS_PORT2_CFG_ADDR, 32'h0, {29'h0, `AMIS_SEL_RESET});
    bus(0, 0, 32'h0, 32'h0, 32'h0);
    chk_mute();
    cmp("pending_reads", 32'h0, exp_q.size());
    finish_test();
  end
endmodule : testbench
